// ### verilog/dsl_link.sv
// One data-strobe serial link endpoint with its APB register slave.
// Assumes pclk at 100 MHz and an asynchronous peer on rx_data/rx_strobe.
//
// Our own choices: the placing of the registers and the APB register port.
`include "dsl_map.svh"

// Overview of operation
// - Data token: parity, flag 0, eight bits
// - Control token: parity, flag 1, two bits
// - Exactly one wire toggles per bit
// - Odd parity over previous and flag
// - Codes: credit, packet end, message end, escape
// - Idle is escape then credit code
// - Receive buffer holds twenty tokens
// - Credit sent per eight free slots
// - Each credit allows eight more tokens
// - Credits never reach packet logic
// - Default rate after reset
// - Receiver decodes from edges, any rate
// - Master factor, per-link divider or default
// - Divide by one or two; others reserved
// - Disconnect only after first token seen
// - Summary, parity and disconnect fault flags
// - Parity fault halts transmit
// - Any fault resets the link
// - Contain-faults mode selects error policy
// - Drop packets when down if enabled
// - Redirect in group when not dropping
// - Policies apply whenever link inactive
// - Outputs low after reset, held at last level after a fault, until first credit sent
// - Quiet 3.2 us then 12.8 us settle
module dsl_link (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rx_data,
  input  wire logic        rx_strobe,
  output logic             tx_data,
  output logic             tx_strobe,
  output logic             link_down,
  output logic             pkt_drop,
  output logic             pkt_redirect,
  output logic             pkt_truncate
);

  typedef struct packed {
    dsl_pkg::dsl_state_e st;
    logic [13:0] tmr;
    logic [4:0]  ctrl;
    logic [5:0]  master_clock_factor;
    logic [1:0]  link_rate_divider;
    logic        link_fault_flag;
    logic        odd_check_fault_flag;
    logic        disconnect_fault_flag;
    logic        tok_seen;
    logic [1:0]  d_s;
    logic [1:0]  s_s;
    logic        d_q;
    logic        s_q;
    logic [9:0]  rsh;
    logic [3:0]  rcnt;
    logic        rpar;
    logic        resc;
    logic        rhave;
    logic [7:0]  dcnt;
    logic [`DSL_RX_DEPTH-1:0][8:0] rx_mem;
    logic [4:0]  rwp;
    logic [4:0]  rrp;
    logic [4:0]  rlvl;
    logic [4:0]  granted;
    logic [8:0]  tx_hold;
    logic        tx_full;
    logic [9:0]  tsh;
    logic [3:0]  tcnt;
    logic        tpar;
    logic        idle_half;
    logic        sent_credit;
    logic [4:0]  tx_allow;
    logic        credit_due;
    logic [7:0]  bdiv;
    logic        tx_data;
    logic        tx_strobe;
    logic [31:0] prdata;
  } dsl_s;

  dsl_s q;
  dsl_s n;

  logic        wr;
  logic        rd;
  logic        tick;
  logic [7:0]  div_max;
  logic [4:0]  free;
  logic        rx_edge;
  logic        rx_bit;

  assign wr      = psel && penable && pwrite;
  assign rd      = psel && penable && !pwrite;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign prdata  = q.prdata;
  assign tx_data   = q.tx_data;
  assign tx_strobe = q.tx_strobe;
  assign free      = `DSL_RX_DEPTH - q.rlvl - q.granted;
  // Link rate is factor x 5 Mb/s over /1 or /2, so a bit lasts 20 x div / factor pclk
  // cycles; rounded up, since a bit cannot start between two pclk edges.
  assign div_max = !q.ctrl[`DSL_CTRL_SPDSEL] ? 8'(`DSL_BASE_DIV) :
                   8'((20 * (32'(q.link_rate_divider[0]) + 1) + 32'(q.master_clock_factor) - 1)
                      / 32'(q.master_clock_factor));
  assign tick    = q.bdiv == 8'h00;
  // Edge detect reads second stage only
  assign rx_edge = (q.d_s[1] ^ q.d_q) | (q.s_s[1] ^ q.s_q);
  assign rx_bit  = q.d_s[1];
  // Packet policy: drop or redirect while link down, truncate on a contained fault
  assign link_down    = q.st != dsl_pkg::DSL_RUN;
  assign pkt_drop     = link_down && q.ctrl[`DSL_CTRL_DROP];
  assign pkt_redirect = link_down && !q.ctrl[`DSL_CTRL_DROP];
  assign pkt_truncate = q.link_fault_flag && q.ctrl[`DSL_CTRL_CONTAIN];

  // ==========================================================
  // Next state
  always_comb begin
    logic [9:0] tok;
    logic       perr;
    logic       fault;
    logic       pop;
    tok   = 10'h000;
    perr  = 1'b0;
    fault = 1'b0;
    pop   = 1'b0;
    n = q;
    n.d_s = {q.d_s[0], rx_data};
    n.s_s = {q.s_s[0], rx_strobe};
    n.d_q = q.d_s[1];
    n.s_q = q.s_s[1];
    n.bdiv = tick ? div_max - 8'h01 : q.bdiv - 8'h01;
    n.prdata = 32'h0000_0000;
    // ========================================================
    // Register access
    // Read data loads in the setup phase so that it stands through the access phase
    if (psel && !penable && !pwrite) begin
      case (paddr)
        `DSL_REG_CTRL:   n.prdata = {27'h0, q.ctrl};
        `DSL_REG_STATUS: n.prdata = {25'h0, q.tok_seen, q.st != dsl_pkg::DSL_RUN,
                                     q.disconnect_fault_flag, q.odd_check_fault_flag,
                                     q.st == dsl_pkg::DSL_RUN, q.link_fault_flag};
        `DSL_REG_SPEED:  n.prdata = {22'h0, q.link_rate_divider, 2'h0, q.master_clock_factor};
        `DSL_REG_RXDATA: n.prdata = {22'h0, q.rlvl != 5'h00, q.rx_mem[q.rrp]};
        `DSL_REG_ID:     n.prdata = `DSL_ID_VALUE;
        default:         n.prdata = 32'h0000_0000;
      endcase
    end
    if (wr) begin
      case (paddr)
        `DSL_REG_CTRL: begin
          n.ctrl = pwdata[4:0];
          if (pwdata[`DSL_CTRL_RESET]) begin
            n.link_fault_flag = 1'b0;
            n.odd_check_fault_flag = 1'b0;
            n.disconnect_fault_flag = 1'b0;
          end
        end
        `DSL_REG_SPEED: begin
          // Factors outside eight to twenty are ignored, keeping the old value, to protect the divider
          if (pwdata[5:0] >= `DSL_MUL_MIN && pwdata[5:0] <= `DSL_MUL_MAX) begin
            n.master_clock_factor = pwdata[5:0];
          end
          if (!pwdata[9]) begin
            n.link_rate_divider = pwdata[9:8];
          end
        end
        `DSL_REG_TXDATA: begin
          if (!q.tx_full) begin
            n.tx_hold = pwdata[8:0];
            n.tx_full = 1'b1;
          end
        end
        default: ;
      endcase
    end
    // Pop only a token that the setup phase showed as valid
    pop = rd && paddr == `DSL_REG_RXDATA && q.prdata[9];
    if (pop) begin
      n.rrp  = (q.rrp == `DSL_RX_DEPTH - 5'h01) ? 5'h00 : q.rrp + 5'h01;
      n.rlvl = q.rlvl - 5'h01;
    end
    // ========================================================
    // Receiver
    if (q.st == dsl_pkg::DSL_WAIT || q.st == dsl_pkg::DSL_RUN) begin
      if (rx_edge) begin
        n.dcnt = 8'h00;
        n.rsh  = {q.rsh[8:0], rx_bit};
        n.rcnt = q.rcnt + 4'h1;
        if (q.rcnt == 4'h1) begin
          // Parity plus flag plus previous payload must be odd
          perr = ~(q.rpar ^ q.rsh[0] ^ rx_bit);
        end
        tok = {q.rsh[8:0], rx_bit};
        if (q.rcnt == 4'h3 && q.rsh[1]) begin
          n.rcnt = 4'h0;
          n.rpar = ^tok[1:0];
          n.tok_seen = 1'b1;
          n.resc = tok[1:0] == `DSL_CT_ESC;
          if (tok[1:0] == `DSL_CT_CREDIT && !q.resc) begin
            n.tx_allow = q.tx_allow + `DSL_CREDIT_BLOCK;
          end else if (tok[1:0] != `DSL_CT_ESC && tok[1:0] != `DSL_CT_CREDIT
                       && q.rlvl < `DSL_RX_DEPTH) begin
            n.rx_mem[q.rwp] = {1'b1, 6'h00, tok[1:0]};
            n.rhave = 1'b1;
          end
        end else if (q.rcnt == 4'h9) begin
          n.rcnt = 4'h0;
          n.rpar = ^tok[7:0];
          n.tok_seen = 1'b1;
          n.resc = 1'b0;
          if (q.rlvl < `DSL_RX_DEPTH) begin
            n.rx_mem[q.rwp] = {1'b0, tok[7:0]};
            n.rhave = 1'b1;
          end
        end
      end else if (q.tok_seen && q.dcnt != 8'(`DSL_DISC_CYC)) begin
        n.dcnt = q.dcnt + 8'h01;
      end
      if (q.tok_seen && q.dcnt == 8'(`DSL_DISC_CYC)) begin
        n.disconnect_fault_flag = 1'b1;
        fault = 1'b1;
      end
      if (perr) begin
        n.odd_check_fault_flag = 1'b1;
        fault = 1'b1;
      end
    end
    if (q.rhave) begin
      n.rhave = 1'b0;
      n.rwp  = (q.rwp == `DSL_RX_DEPTH - 5'h01) ? 5'h00 : q.rwp + 5'h01;
      n.rlvl = n.rlvl + 5'h01;
      if (q.granted != 5'h00) begin
        n.granted = q.granted - 5'h01;
      end
    end
    if (free >= `DSL_CREDIT_BLOCK && !q.credit_due && q.st == dsl_pkg::DSL_RUN) begin
      n.credit_due = 1'b1;
      n.granted    = n.granted + `DSL_CREDIT_BLOCK;
    end
    // ========================================================
    // Transmitter: one bit per tick, MSB first
    if (q.st == dsl_pkg::DSL_RUN && tick) begin
      if (q.tcnt != 4'h0) begin
        n.tsh  = {q.tsh[8:0], 1'b0};
        n.tcnt = q.tcnt - 4'h1;
        n.tx_data = q.tsh[9];
        n.tx_strobe = (q.tsh[9] == q.tx_data) ? ~q.tx_strobe : q.tx_strobe;
      end
      // The next token loads while the last bit of this one goes out
      if (q.tcnt <= 4'h1 && (q.credit_due || q.idle_half)) begin
        // Credit token, or second half of an idle
        n.tsh  = {~(q.tpar ^ 1'b1), 1'b1, `DSL_CT_CREDIT, 6'h00};
        n.tcnt = `DSL_CTRL_BITS;
        n.tpar = 1'b0;
        n.idle_half = 1'b0;
        n.sent_credit = 1'b1;
        if (!q.idle_half) begin
          n.credit_due = 1'b0;
        end
      end else if (q.tcnt <= 4'h1 && q.sent_credit && q.tx_full && q.tx_allow != 5'h00) begin
        n.tx_full  = 1'b0;
        n.tx_allow = n.tx_allow - 5'h01;
        n.tcnt = q.tx_hold[8] ? `DSL_CTRL_BITS : `DSL_DATA_BITS;
        n.tpar = q.tx_hold[8] ? ^q.tx_hold[1:0] : ^q.tx_hold[7:0];
        n.tsh  = q.tx_hold[8] ? {q.tpar, 1'b1, q.tx_hold[1:0], 6'h00}
                              : {~q.tpar, 1'b0, q.tx_hold[7:0]};
      end else if (q.tcnt <= 4'h1 && q.sent_credit) begin
        n.tsh  = {~(q.tpar ^ 1'b1), 1'b1, `DSL_CT_ESC, 6'h00};
        n.tcnt = `DSL_CTRL_BITS;
        n.tpar = 1'b0;
        n.idle_half = 1'b1;
      end
    end
    // ========================================================
    // Link state
    case (q.st)
      dsl_pkg::DSL_IDLE: begin
        if (q.ctrl[`DSL_CTRL_START] && !q.ctrl[`DSL_CTRL_RESET]) begin
          n.st = dsl_pkg::DSL_WAIT;
        end
      end
      dsl_pkg::DSL_WAIT: n.st = dsl_pkg::DSL_RUN;
      dsl_pkg::DSL_RUN: begin
        if (q.ctrl[`DSL_CTRL_RESET]) begin
          fault = 1'b1;
        end
      end
      dsl_pkg::DSL_QUIET: begin
        // Inputs ignored while quiet
        if (q.tmr == 14'h0000) begin
          n.st  = dsl_pkg::DSL_SETTLE;
          n.tmr = 14'(`DSL_SETTLE_CYC - 1);
        end else begin
          n.tmr = q.tmr - 14'h0001;
        end
      end
      dsl_pkg::DSL_SETTLE: begin
        if (q.tmr == 14'h0000) begin
          n.st = dsl_pkg::DSL_IDLE;
        end else begin
          n.tmr = q.tmr - 14'h0001;
        end
      end
      default: n.st = dsl_pkg::DSL_IDLE;
    endcase
    if (fault || (q.ctrl[`DSL_CTRL_RESET] && q.st == dsl_pkg::DSL_WAIT)) begin
      n.link_fault_flag = n.odd_check_fault_flag | n.disconnect_fault_flag;
      n.st = dsl_pkg::DSL_QUIET;
      n.tmr = 14'(`DSL_QUIET_CYC - 1);
      n.ctrl[`DSL_CTRL_START] = 1'b0;
      n.tcnt = 4'h0;
      n.tok_seen = 1'b0;
      n.sent_credit = 1'b0;
      n.tx_allow = 5'h00;
      n.credit_due = 1'b0;
      n.granted = 5'h00;
      n.idle_half = 1'b0;
      n.tpar = 1'b0;
      n.rcnt = 4'h0;
      n.resc = 1'b0;
      n.rpar = 1'b0;
      n.dcnt = 8'h00;
      n.rlvl = 5'h00;
      n.rwp = 5'h00;
      n.rrp = 5'h00;
      n.rhave = 1'b0;
      n.tx_full = 1'b0;
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.master_clock_factor <= `DSL_MUL_RESET;
    end else begin
      q <= n;
    end
  end

  // ==========================================================
  // Checks
  sequence quiet_entry;
    q.st == dsl_pkg::DSL_QUIET && $past(q.st) != dsl_pkg::DSL_QUIET;
  endsequence

  chk_low_before_credit: assert property (@(posedge pclk) disable iff (!presetn)
    !q.sent_credit |-> $stable({tx_data, tx_strobe})) else $error("output moved before credit");
  chk_one_wire_flip: assert property (@(posedge pclk) disable iff (!presetn)
    !$stable({tx_data, tx_strobe}) |-> $onehot({tx_data ^ $past(tx_data),
      tx_strobe ^ $past(tx_strobe)})) else $error("both wires changed");
  chk_no_data_sans_grant: assert property (@(posedge pclk) disable iff (!presetn)
    (q.tx_full && !n.tx_full && q.st == dsl_pkg::DSL_RUN) |-> q.tx_allow != 5'h00)
    else $error("data sent without credit");
  chk_parity_halts: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(q.odd_check_fault_flag) |-> q.st == dsl_pkg::DSL_QUIET && q.tcnt == 4'h0)
    else $error("parity fault did not halt link");
  chk_fault_summary: assert property (@(posedge pclk) disable iff (!presetn)
    (q.odd_check_fault_flag || q.disconnect_fault_flag) |-> q.link_fault_flag)
    else $error("summary flag missing");
  chk_disc_needs_token: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(q.disconnect_fault_flag) |-> $past(q.tok_seen)) else $error("disconnect unstarted");
  chk_quiet_length: assert property (@(posedge pclk) disable iff (!presetn)
    quiet_entry |-> (q.st == dsl_pkg::DSL_QUIET) [*8]) else $error("quiet too short");
  chk_default_speed: assert property (@(posedge pclk) disable iff (!presetn)
    !q.ctrl[`DSL_CTRL_SPDSEL] |-> div_max == 8'(`DSL_BASE_DIV)) else $error("bad default rate");
  chk_drop_policy: assert property (@(posedge pclk) disable iff (!presetn)
    (link_down && q.ctrl[`DSL_CTRL_DROP]) |-> pkt_drop && !pkt_redirect)
    else $error("drop policy wrong");
  chk_buffer_bound: assert property (@(posedge pclk) disable iff (!presetn)
    q.rlvl <= `DSL_RX_DEPTH) else $error("buffer overrun");

endmodule

// ### verilog/dsl_map.svh
// Constants of the data-strobe link block: token codes, timing, speed settings.
// Assumes inclusion by bare name from the testbench and the link module.
`ifndef DSL_MAP_SVH
`define DSL_MAP_SVH

// Register byte addresses
`define DSL_REG_CTRL      12'h000
`define DSL_REG_STATUS    12'h004
`define DSL_REG_SPEED     12'h008
`define DSL_REG_RXDATA    12'h00c
`define DSL_REG_TXDATA    12'h010
`define DSL_REG_ID        12'h014
`define DSL_ID_VALUE      32'h0000_5a5a
// Control bits
`define DSL_CTRL_START    0
`define DSL_CTRL_RESET    1
`define DSL_CTRL_SPDSEL   2
`define DSL_CTRL_CONTAIN  3
`define DSL_CTRL_DROP     4
// Token field codes (the two type bits that follow the flag)
`define DSL_CT_CREDIT     2'h0
`define DSL_CT_PEND       2'h1
`define DSL_CT_MEND       2'h2
`define DSL_CT_ESC        2'h3
`define DSL_DATA_BITS     4'ha
`define DSL_CTRL_BITS     4'h4
`define DSL_CREDIT_BLOCK  5'h08
`define DSL_RX_DEPTH      5'h14
`define DSL_RX_AW         5
// Timing, 100 MHz pclk
`define DSL_CLK_NS        10
`define DSL_QUIET_NS      3200
`define DSL_SETTLE_NS     12800
`define DSL_QUIET_CYC     ((`DSL_QUIET_NS + `DSL_CLK_NS - 1) / `DSL_CLK_NS)
`define DSL_SETTLE_CYC    ((`DSL_SETTLE_NS + `DSL_CLK_NS - 1) / `DSL_CLK_NS)
`define DSL_BASE_DIV      10
`define DSL_DISC_CYC      100
`define DSL_MUL_MIN       6'h08
`define DSL_MUL_MAX       6'h14
`define DSL_MUL_RESET     6'h08
`endif

// ### verilog/dsl_pkg.sv
// Types shared by the data-strobe link block.
// Assumes nothing from dsl_map.svh; no include is made here.
package dsl_pkg;
  typedef enum logic [2:0] {
    DSL_IDLE   = 3'b000,
    DSL_WAIT   = 3'b001,
    DSL_RUN    = 3'b011,
    DSL_QUIET  = 3'b010,
    DSL_SETTLE = 3'b110
  } dsl_state_e;
endpackage

// ### tb/dsl_peer.sv
// Behavioural peer endpoint facing the device across the data-strobe wires.
// Assumes the bench clock; its bit period is a parameter, unrelated to the device rate.
module dsl_peer #(
  parameter int BIT_CYC = 7
) (
  input  wire logic clk,
  input  wire logic run,
  input  wire logic in_d,
  input  wire logic in_s,
  output logic      out_d,
  output logic      out_s
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [9:0] txq[$];
  int         credit_in, sent, cr_out, rx_tok, par_err, both_err, edges, gap, min_gap;
  logic [7:0] last_byte;
  logic [1:0] last_ctrl;
  logic [9:0] sh;
  logic       tx_prev, rx_prev, pd, ps, fl, esc_seen;
  int         n;
  // ==========================================================================
  // Transmit side
  task automatic put_bit(input logic b);
    if (b === out_d) out_s <= ~out_s;
    out_d <= b;
    repeat (BIT_CYC) @(posedge clk);
  endtask
  // Bit 9 of an entry corrupts its parity on purpose
  task automatic put_tok(input logic [9:0] t);
    put_bit(~(tx_prev ^ t[8]) ^ t[9]);
    put_bit(t[8]);
    for (int i = (t[8] ? 1 : 7); i >= 0; i--) put_bit(t[i]);
    tx_prev = t[8] ? ^t[1:0] : ^t[7:0];
  endtask
  initial begin
    out_d = 1'b0;
    out_s = 1'b0;
    tx_prev = 1'b0;
    forever begin
      @(posedge clk);
      if (!run) begin
        tx_prev = 1'b0;
        sent = 0;
        cr_out = 0;
      end else if (rx_tok + 16 > cr_out * 8) begin
        put_tok(10'h100);
        cr_out++;
      end else if (txq.size() > 0 && sent < credit_in * 8) begin
        put_tok(txq.pop_front());
        sent++;
      end else begin
        put_tok(10'h103);
        put_tok(10'h100);
      end
    end
  end
  // ==========================================================================
  // Receive side: a long silence means the device restarted
  initial begin
    pd = 1'b0; ps = 1'b0; gap = 0; min_gap = 1000; edges = 0; par_err = 0; both_err = 0;
    n = 0; rx_prev = 1'b0; esc_seen = 1'b0; credit_in = 0; rx_tok = 0;
  end
  always @(posedge clk) begin
    pd <= in_d;
    ps <= in_s;
    gap++;
    if (gap > 200) begin
      n = 0; rx_prev = 1'b0; esc_seen = 1'b0; credit_in = 0; rx_tok = 0;
    end
    if ((in_d ^ pd) | (in_s ^ ps)) begin
      if ((in_d ^ pd) & (in_s ^ ps)) both_err++;
      edges++;
      if (gap < min_gap) min_gap = gap;
      gap = 0;
      sh = {sh[8:0], in_d};
      n++;
      if (n == 2) fl = in_d;
      if ((n == 4 && fl) || n == 10) begin
        if (((fl ? sh[3] : sh[9]) ^ fl ^ rx_prev) !== 1'b1) par_err++;
        rx_prev = fl ? ^sh[1:0] : ^sh[7:0];
        n = 0;
        if (!fl) begin
          last_byte = sh[7:0];
          rx_tok++;
        end else if (esc_seen) esc_seen = 1'b0;
        else if (sh[1:0] == 2'h3) esc_seen = 1'b1;
        else if (sh[1:0] == 2'h0) credit_in++;
        else begin
          last_ctrl = sh[1:0];
          rx_tok++;
        end
      end
    end
  end
endmodule

// ### tb/testbench.sv
// Self-checking bench for the data-strobe link endpoint and its APB registers.
// Assumes dsl_map.svh on the include path and the peer model beside it.
`include "dsl_map.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, peer_run;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, e, spd;
  logic        rx_data, rx_strobe, tx_data, tx_strobe;
  logic        link_down, pkt_drop, pkt_redirect, pkt_truncate;
  logic [8:0]  exp_q[$], v;
  int          errors, checks_done, k;
  dsl_link i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_data(rx_data), .rx_strobe(rx_strobe), .tx_data(tx_data),
    .tx_strobe(tx_strobe), .link_down(link_down), .pkt_drop(pkt_drop),
    .pkt_redirect(pkt_redirect), .pkt_truncate(pkt_truncate));
  dsl_peer i_peer (.clk(pclk), .run(peer_run), .in_d(tx_data), .in_s(tx_strobe),
    .out_d(rx_data), .out_s(rx_strobe));
  // ==========================================================================
  // Shared tasks
  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic bound(input int used, input int lim);
    if (used >= lim) begin
      errors++;
      $display("wrong value wait bound expected below %0d seen %0d", lim, used);
      finish_test();
    end
  endtask
  // Read data is taken at the edge that sees pready; an idle cycle separates transfers
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int w;
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    w = 0;
    do begin @(posedge pclk); w++; end while (pready !== 1'b1 && w < 100);
    bound(w, 100);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Bit period in pclk cycles of a factor x 5 Mb/s link over /1 or /2, rounded up
  function automatic int bit_cyc(input logic [31:0] s);
    int f;
    f = int'(s[5:0]);
    return (20 * (int'(s[8]) + 1) + f - 1) / f;
  endfunction
  task automatic poll_status(input logic [31:0] m, input logic [31:0] want);
    int w;
    w = 0;
    do begin apb(1'b0, `DSL_REG_STATUS, 32'h0); w++; end while ((rd & m) !== want && w < 400);
    bound(w, 400);
  endtask
  // ==========================================================================
  // Main sequence
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
    pwdata = 32'h0; peer_run = 1'b0; errors = 0; checks_done = 0;
    rd = $urandom(32'h67ab);
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check("pins after reset", 32'({tx_data, tx_strobe, link_down, pkt_drop, pkt_redirect,
      pkt_truncate}), 32'h0a);
    apb(1'b0, `DSL_REG_ID, 32'h0);
    check("id", rd, `DSL_ID_VALUE);
    apb(1'b0, `DSL_REG_STATUS, 32'h0);
    check("status after reset", rd, 32'h10);
    apb(1'b0, 12'h0f0, 32'h0);
    check("unmapped read", rd, 32'h0);
    e = {22'h0, 2'($urandom % 2), 2'h0, 6'(8 + 2 * ($urandom % 7))};
    apb(1'b1, `DSL_REG_SPEED, e);
    apb(1'b0, `DSL_REG_SPEED, 32'h0);
    check("speed readback", rd, e);
    spd = e;
    $display("test registers done");
    apb(1'b1, `DSL_REG_CTRL, 32'h09);
    repeat (400) @(posedge pclk);
    apb(1'b0, `DSL_REG_STATUS, 32'h0);
    check("no disconnect before peer", rd & 32'h9, 32'h0);
    check("credits from fresh buffer", i_peer.credit_in, 2);
    peer_run <= 1'b1;
    poll_status(32'h22, 32'h22);
    check("link up", link_down, 1'b0);
    $display("test start done");
    for (int i = 0; i < 10; i++) begin
      v = (i == 3) ? 9'h101 : (i == 7) ? 9'h102 : {1'b0, 8'($urandom)};
      e = i_peer.rx_tok;
      apb(1'b1, `DSL_REG_TXDATA, {23'h0, v});
      for (k = 0; k < 600 && i_peer.rx_tok == e; k++) @(posedge pclk);
      bound(k, 600);
      if (v[8]) check("sent control type", i_peer.last_ctrl, v[1:0]);
      else check("sent byte", i_peer.last_byte, v[7:0]);
    end
    $display("test transmit done");
    for (int i = 0; i < 20; i++) begin
      v = (i == 5) ? 9'h101 : {1'b0, 8'($urandom)};
      exp_q.push_back(v);
      i_peer.txq.push_back({1'b0, v});
    end
    repeat (2500) @(posedge pclk);
    check("tokens before stall", i_peer.sent, 16);
    for (k = 0; k < 300 && exp_q.size() > 0; k++) begin
      apb(1'b0, `DSL_REG_RXDATA, 32'h0);
      if (rd[9] === 1'b1) check("received token", rd[8:0], exp_q.pop_front());
    end
    bound(k, 300);
    apb(1'b0, `DSL_REG_RXDATA, 32'h0);
    check("buffer drained", rd[9], 1'b0);
    $display("test receive done");
    i_peer.txq.push_back(10'h2a5);
    poll_status(32'h1, 32'h1);
    check("parity fault status", rd & 32'h7, 32'h5);
    check("contained policy pins", 32'({link_down, pkt_drop, pkt_redirect, pkt_truncate}),
      32'hb);
    repeat (200) @(posedge pclk);
    e = i_peer.edges;
    repeat (300) @(posedge pclk);
    check("transmit halted", i_peer.edges, e);
    check("default bit period", i_peer.min_gap, `DSL_BASE_DIV);
    i_peer.min_gap = 1000;
    peer_run <= 1'b0;
    apb(1'b1, `DSL_REG_CTRL, 32'h02);
    repeat (`DSL_QUIET_CYC + `DSL_SETTLE_CYC + 100) @(posedge pclk);
    apb(1'b1, `DSL_REG_CTRL, 32'h15);
    peer_run <= 1'b1;
    poll_status(32'h23, 32'h22);
    check("drop idle while up", pkt_drop, 1'b0);
    peer_run <= 1'b0;
    poll_status(32'h9, 32'h9);
    check("drop policy pins", 32'({link_down, pkt_drop, pkt_redirect, pkt_truncate}),
      32'hc);
    check("peer parity faults", i_peer.par_err, 0);
    check("both wires toggled", i_peer.both_err, 0);
    check("selected bit period", i_peer.min_gap, bit_cyc(spd));
    $display("test faults done");
    finish_test();
  end
endmodule
